// ===== rtl/ptd_cfg.svh
// constants for the per-process table entry decoder
// assumes inclusion by the decoder module only
`ifndef PTD_CFG_SVH
`define PTD_CFG_SVH
`define PTD_DIR_BASE_OFFSET 16'h2518
`define PTD_DIR_BASE_RESET 32'h0000_0000
`define PTD_DIR_BASE_MASK 32'h7fff_0000
`define PTD_PAGE_SHIFT 12
`define PTD_DIR_SPAN_SHIFT 22
`define PTD_BIG_PAGE_SHIFT 15
`define PTD_LAT_CYCLES 1
`define PTD_DIR_VALID_BIT 0
`define PTD_DIR_SIZE_BIT 1
`endif

// ===== rtl/ptd_pkg.sv
// types for the per-process table entry decoder
// assumes ptd_cfg.svh supplies the numeric constants
`default_nettype none
package ptd_pkg;
	typedef enum logic [1:0] {
		CACHE_RESERVED,
		CACHE_NONE,
		CACHE_LAST_LEVEL,
		CACHE_BOTH
	} ptd_cache_t;
	typedef struct packed {
		logic [19:0] page_lo;
		logic [7:0] page_hi;
		logic graphics_data_type_flag;
		logic [1:0] cache_ctl;
		logic valid;
	} ptd_entry_t;
	typedef struct packed {
		logic valid;
		logic [39:0] phys_addr;
		logic mid_level_cache;
		logic last_level_cache;
		logic graphics_data_type_flag;
		logic entry_error;
		logic dir_fault;
		logic reserved_code;
	} ptd_result_t;
	typedef struct packed {
		logic [31:0] page_directory_base;
		logic [31:0] rdata;
		ptd_result_t res;
	} ptd_state_t;
endpackage
`default_nettype wire

// ===== rtl/ptd_decode.sv
// table entry decoder: turns one second-level entry plus a virtual offset into a
// physical address, cache attributes and error flags; holds the directory base register.
// assumes the entry and directory entry come from logic on the same clock.
// Functional notes
// - each 32-bit entry maps exactly one 4KB graphics page, or one 32KB page when the directory entry selects big pages
// - entries change by memory writes or the table update command
// - valid entry bits 31:12 give physical address bits 31:12
// - entry bits 11:4 give physical address bits 39:32
// - write data type flag is entry bit 3 OR command flag
// - entry bit 3 ignored on reads, default zero
// - bits 2:1 select caching; 01 none, 10 last-level, 11 both
// - bit 0 valid; mapping used only when it is one
// - non-host-read access through invalid entry raises entry error
// - directory base register at 2518h, resets zero, read/write
// - each directory entry covers one page table spanning 4MB
// - directory entries select 4KB or 32KB pages, 32KB aligned
// - invalid directory entry gives page fault, no table lookup
// - directory base bits 30:16 are cacheline offset of directory
`include "ptd_cfg.svh"
`default_nettype none
module ptd_decode (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// translation request
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic req_host_read_i,
	input wire logic req_cmd_graphics_data_type_flag_i,
	input wire logic [31:0] req_vaddr_i,
	input wire logic [31:0] dir_entry_i,
	input wire ptd_pkg::ptd_entry_t table_entry_i,
	// register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	output logic [31:0] reg_rdata_o,
	output logic [31:0] page_directory_base_o,
	// translation result
	output ptd_pkg::ptd_result_t res_o
);
	ptd_pkg::ptd_state_t st;
	ptd_pkg::ptd_state_t next_st;
	logic dir_valid;
	logic dir_big;
	logic [39:0] base;

	// page offset width is fixed by the 4KB page
	if (`PTD_PAGE_SHIFT != 12) begin : g_bad_page_shift
		$error("page shift must be 12");
	end
	// one table of 4-byte entries spans 4MB
	if (`PTD_DIR_SPAN_SHIFT - `PTD_PAGE_SHIFT != 10) begin : g_bad_dir_span
		$error("directory entry must span 1024 pages");
	end
	if (`PTD_BIG_PAGE_SHIFT != 15) begin : g_bad_big_page
		$error("big page shift must be 15");
	end

	always_comb begin
		next_st = st;
		dir_valid = dir_entry_i[`PTD_DIR_VALID_BIT];
		dir_big = dir_entry_i[`PTD_DIR_SIZE_BIT];
		base = {table_entry_i.page_hi, table_entry_i.page_lo, 12'h000};
		if (reg_wr_i && reg_addr_i == `PTD_DIR_BASE_OFFSET) begin
			next_st.page_directory_base = reg_wdata_i & `PTD_DIR_BASE_MASK;
		end
		if (reg_rd_i) begin
			next_st.rdata = (reg_addr_i == `PTD_DIR_BASE_OFFSET) ? st.page_directory_base : 32'h0000_0000;
		end
		next_st.res = '0;
		if (req_i) begin
			if (!dir_valid) begin
				next_st.res.dir_fault = 1'b1;
			end else begin
				next_st.res.valid = table_entry_i.valid;
				if (dir_big)
					next_st.res.phys_addr = {base[39:`PTD_BIG_PAGE_SHIFT], req_vaddr_i[`PTD_BIG_PAGE_SHIFT-1:0]};
				else
					next_st.res.phys_addr = {base[39:`PTD_PAGE_SHIFT], req_vaddr_i[`PTD_PAGE_SHIFT-1:0]};
				unique case (ptd_pkg::ptd_cache_t'(table_entry_i.cache_ctl))
					ptd_pkg::CACHE_RESERVED: next_st.res.reserved_code = 1'b1;
					ptd_pkg::CACHE_NONE: ;
					ptd_pkg::CACHE_LAST_LEVEL: next_st.res.last_level_cache = 1'b1;
					ptd_pkg::CACHE_BOTH: begin
						next_st.res.last_level_cache = 1'b1;
						next_st.res.mid_level_cache = 1'b1;
					end
				endcase
				next_st.res.graphics_data_type_flag = req_write_i &
					(table_entry_i.graphics_data_type_flag | req_cmd_graphics_data_type_flag_i);
				next_st.res.entry_error = !table_entry_i.valid && !req_host_read_i;
				if (!table_entry_i.valid) begin
					next_st.res.phys_addr = '0;
					next_st.res.mid_level_cache = 1'b0;
					next_st.res.last_level_cache = 1'b0;
					next_st.res.graphics_data_type_flag = 1'b0;
				end
			end
		end
	end

	// no copy of an entry is kept, so an update in memory is seen on the next lookup
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{page_directory_base: `PTD_DIR_BASE_RESET, rdata: 32'h0000_0000, res: '0};
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign reg_rdata_o = st.rdata;
	assign page_directory_base_o = st.page_directory_base;
	assign res_o = st.res;

	chk_entry_error_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && dir_entry_i[0] && !table_entry_i.valid && !req_host_read_i |=> res_o.entry_error)
		else $error("invalid entry did not raise error");
	chk_host_read_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && req_host_read_i |=> !res_o.entry_error)
		else $error("host read raised entry error");
	chk_dir_fault: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && !dir_entry_i[0] |=> res_o.dir_fault && !res_o.valid)
		else $error("invalid directory entry not faulted");
	chk_addr_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && dir_entry_i[0] && !dir_entry_i[1] && table_entry_i.valid |=>
		res_o.phys_addr == {$past(table_entry_i.page_hi), $past(table_entry_i.page_lo), $past(req_vaddr_i[11:0])})
		else $error("physical address mismatch");
	chk_graphics_data_type_flag_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && !req_write_i |=> !res_o.graphics_data_type_flag)
		else $error("data type flag set on read");
	chk_graphics_data_type_flag_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && req_write_i && dir_entry_i[0] && table_entry_i.valid && req_cmd_graphics_data_type_flag_i
		|=> res_o.graphics_data_type_flag)
		else $error("command data type flag lost");
	chk_cache_mid: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		res_o.mid_level_cache |-> res_o.last_level_cache)
		else $error("mid level cached without last level");
	chk_reserved_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		res_o.reserved_code |-> !res_o.last_level_cache && !res_o.mid_level_cache)
		else $error("reserved code cached");
	chk_base_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && reg_wr_i && reg_addr_i == `PTD_DIR_BASE_OFFSET |=>
		page_directory_base_o == ($past(reg_wdata_i) & `PTD_DIR_BASE_MASK))
		else $error("directory base not written");
	chk_valid_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!res_o.valid |-> res_o.phys_addr == 40'h00_0000_0000 && !res_o.mid_level_cache && !res_o.last_level_cache)
		else $error("invalid mapping leaked address");
	chk_cache_both: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && dir_entry_i[0] && table_entry_i.valid && table_entry_i.cache_ctl == 2'b11
		|=> res_o.mid_level_cache && res_o.last_level_cache && !res_o.reserved_code)
		else $error("code for both caches not decoded");
	chk_cache_last: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && dir_entry_i[0] && table_entry_i.valid && table_entry_i.cache_ctl == 2'b10
		|=> !res_o.mid_level_cache && res_o.last_level_cache && !res_o.reserved_code)
		else $error("code for last level cache not decoded");
	chk_cache_none: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && dir_entry_i[0] && table_entry_i.valid && table_entry_i.cache_ctl == 2'b01
		|=> !res_o.mid_level_cache && !res_o.last_level_cache && !res_o.reserved_code)
		else $error("uncached code not decoded");
	chk_reserved_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && dir_entry_i[0] && table_entry_i.valid && table_entry_i.cache_ctl == 2'b00
		|=> res_o.reserved_code && !res_o.mid_level_cache && !res_o.last_level_cache)
		else $error("reserved code not flagged");
	chk_big_page: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && dir_entry_i[0] && dir_entry_i[1] && table_entry_i.valid |=>
		res_o.phys_addr == {$past(table_entry_i.page_hi), $past(table_entry_i.page_lo[19:3]), $past(req_vaddr_i[14:0])})
		else $error("big page address mismatch");
	chk_graphics_data_type_flag_entry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && req_write_i && dir_entry_i[0] && table_entry_i.valid && table_entry_i.graphics_data_type_flag
		|=> res_o.graphics_data_type_flag)
		else $error("entry data type flag lost");
	chk_valid_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && dir_entry_i[0] && table_entry_i.valid
		|=> res_o.valid && !res_o.entry_error && !res_o.dir_fault)
		else $error("valid mapping not reported");
	chk_invalid_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && dir_entry_i[0] && !table_entry_i.valid |=> !res_o.valid &&
		res_o.phys_addr == 40'h00_0000_0000 && !res_o.last_level_cache && !res_o.graphics_data_type_flag)
		else $error("invalid entry not cleared");
	chk_result_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !req_i |=> res_o == '0)
		else $error("result stood without a request");
	chk_fault_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && req_i && !dir_entry_i[0] |=> res_o.phys_addr == 40'h00_0000_0000 &&
		!res_o.entry_error && !res_o.last_level_cache && !res_o.mid_level_cache)
		else $error("faulted access looked up a table");
	chk_read_base: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && reg_rd_i && reg_addr_i == `PTD_DIR_BASE_OFFSET |=> reg_rdata_o == $past(page_directory_base_o))
		else $error("directory base read mismatch");
	chk_read_unmapped: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && reg_rd_i && reg_addr_i != `PTD_DIR_BASE_OFFSET |=> reg_rdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_base_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ce_i && !(reg_wr_i && reg_addr_i == `PTD_DIR_BASE_OFFSET) |=> $stable(page_directory_base_o))
		else $error("directory base changed without a write");
	// everything holds while the clock enable is low
	chk_freeze_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!ce_i |=> $stable(res_o) && $stable(reg_rdata_o) && $stable(page_directory_base_o))
		else $error("state moved while frozen");
	cov_valid_xlate: cover property (@(posedge clk_i) res_o.valid && res_o.mid_level_cache);
	cov_entry_err: cover property (@(posedge clk_i) res_o.entry_error);
	cov_dir_fault: cover property (@(posedge clk_i) res_o.dir_fault);
	cov_base_wr: cover property (@(posedge clk_i) ce_i && reg_wr_i && reg_addr_i == `PTD_DIR_BASE_OFFSET);
	cov_big_page: cover property (@(posedge clk_i) ce_i && req_i && dir_entry_i[0] && dir_entry_i[1]);
endmodule
`default_nettype wire

// ===== verification/ptd_mem_model.sv
// page table memory that feeds entries to the decoder
// assumes the bench writes every entry before it is looked up
`default_nettype none
module ptd_mem_model (
	// write side
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [3:0] idx_i,
	input wire logic [31:0] wdata_i,
	// lookup side
	input wire logic [3:0] look_i,
	output logic [31:0] entry_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] mem [16];
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[idx_i] <= wdata_i;
		end
	end
	assign entry_o = mem[look_i];
endmodule
`default_nettype wire

// ===== verification/per_process_page_table_entry_decode_tb.sv
// self-checking bench for the table entry decoder
// assumes one clock; inputs change on the falling edge
`default_nettype none
module per_process_page_table_entry_decode_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_n_i = 0, req_i = 0, wr = 0, host = 0, cmd = 0, reg_wr = 0, reg_rd = 0, we = 0, ce = 1;
	logic [3:0] idx = 0;
	logic [15:0] addr = 0;
	logic [31:0] vaddr = 0, dir = 0, wd = 0, ent, rdata, base;
	ptd_pkg::ptd_result_t res;
	int fails = 0, check_count = 0, cyc = 0;
	ptd_mem_model u_mem (.clk_i(clk_i), .we_i(we), .idx_i(idx), .wdata_i(wd), .look_i(vaddr[15:12]), .entry_o(ent));
	ptd_decode u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .req_i(req_i), .req_write_i(wr),
		.req_host_read_i(host), .req_cmd_graphics_data_type_flag_i(cmd), .req_vaddr_i(vaddr), .dir_entry_i(dir),
		.table_entry_i(ent), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(addr),
		.reg_wdata_i(wd), .reg_rdata_o(rdata), .page_directory_base_o(base), .res_o(res));
	initial forever #20 clk_i = ~clk_i;
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic reg_op(input logic w, input logic [15:0] a, input logic [31:0] d);
		{addr, wd, reg_wr, reg_rd} = {a, d, w, !w};
		@(negedge clk_i);
		{reg_wr, reg_rd} = 2'b00;
		// strobes stay low one cycle so a following call never reassigns them in one step
		@(negedge clk_i);
	endtask
	// entry goes to memory first, then one request cycle; result stands at the next fall
	task automatic xlate(input logic [31:0] e, va, d, input logic w, h, c);
		{we, idx, wd} = {1'b1, va[15:12], e};
		@(negedge clk_i);
		{vaddr, dir, wr, host, cmd, req_i, we} = {va, d, w, h, c, 2'b10};
		@(negedge clk_i);
		req_i = 0;
	endtask
	task automatic t_reg();
		check("base reset", base, 32'h0);
		reg_op(1'b1, 16'h2518, 32'hffff_ffff);
		reg_op(1'b1, 16'h2500, 32'h0);
		check("base mask", base, 32'h7fff_0000);
		reg_op(1'b0, 16'h2518, 32'h0);
		check("base read", rdata, 32'h7fff_0000);
		reg_op(1'b0, 16'h251c, 32'h0);
		check("unmapped read", rdata, 32'h0);
	endtask
	task automatic t_map();
		xlate(32'h89ab_c5a7, 32'h0000_3def, 32'h1, 1'b1, 1'b0, 1'b1);
		check("map hi", {res.valid, res.phys_addr, res.graphics_data_type_flag}, {1'b1, 40'h5a_89ab_cdef, 1'b1});
		// page below 4GB carries a zero extension
		xlate(32'h1357_900f, 32'h0000_1123, 32'h1, 1'b1, 1'b0, 1'b0);
		check("map wr", {res.phys_addr, res.graphics_data_type_flag}, {40'h00_1357_9123, 1'b1});
		xlate(32'h1357_900f, 32'h0000_1123, 32'h1, 1'b0, 1'b0, 1'b0);
		check("map rd", res.graphics_data_type_flag, 1'b0);
		xlate(32'h2468_800f, 32'h0000_7abc, 32'h3, 1'b0, 1'b0, 1'b0);
		check("big page", {res.valid, res.phys_addr}, {1'b1, 40'h00_2468_fabc});
	endtask
	task automatic t_cache();
		for (int k = 0; k < 4; k++) begin
			xlate({20'h1, 8'h0, 1'b0, k[1:0], 1'b1}, 32'h1000, 32'h1, 1'b0, 1'b0, 1'b0);
			check("cache", {res.mid_level_cache, res.last_level_cache, res.reserved_code}, {k == 3, k >= 2, k == 0});
		end
	endtask
	task automatic t_err();
		xlate(32'h1234_5006, 32'h5000, 32'h1, 1'b1, 1'b0, 1'b0);
		check("invalid wr", {res.entry_error, res.valid, res.phys_addr, res.last_level_cache},
			{1'b1, 1'b0, 40'h0, 1'b0});
		xlate(32'h1234_5006, 32'h5000, 32'h1, 1'b0, 1'b1, 1'b0);
		check("host rd", res.entry_error, 1'b0);
		xlate(32'h1234_5007, 32'h5000, 32'h0, 1'b1, 1'b0, 1'b0);
		check("dir fault", {res.dir_fault, res.valid, res.entry_error}, {1'b1, 1'b0, 1'b0});
		@(negedge clk_i);
		check("idle", res, '0);
	endtask
	// clock enable low must freeze the register and the result
	task automatic t_hold();
		ce = 1'b0;
		reg_op(1'b1, 16'h2518, 32'h0001_0000);
		xlate(32'h1357_900f, 32'h0000_1123, 32'h1, 1'b1, 1'b0, 1'b0);
		check("frozen base", base, 32'h7fff_0000);
		check("frozen result", res, '0);
		ce = 1'b1;
		reg_op(1'b1, 16'h2518, 32'h0001_0000);
		check("base rewrite", base, 32'h0001_0000);
	endtask
	initial begin
		repeat (12) @(negedge clk_i);
		rst_n_i = 1;
		t_reg();
		t_map();
		t_cache();
		t_err();
		t_hold();
		give_verdict();
	end
endmodule
`default_nettype wire
